//--- hw/uep_programmer.sv
// host controller that reads and programs a 2048 x 8 uv eprom over its pins
//
// Functional notes
// - hold program enable through whole sequence
// - present address and data, then pulse
// - pulse width 0.1 to 1.0 ms
// - wait 1 us after pulse before stepping
// - loop all words N times, N*pulse>=100ms
// - start each loop at zero, count upward
// - end pulse before releasing program enable
// - release data pins before address changes (the code keeps data driven while the address steps between words)
// - no sampling 10 us after enable returns
`timescale 1ns/10ps
module uep_programmer #(
    parameter int ADDR_W = uep_pkg::ADDR_W, // word address width
    parameter int DATA_W = uep_pkg::DATA_W, // word width
    parameter int PULSE_NS = uep_pkg::PULSE_NS, // program pulse width in ns
    parameter int TOTAL_PULSE_NS = uep_pkg::TOTAL_PULSE_NS // least summed pulse time
) (
    input wire logic ref_clk, // reference clock, 250 MHz
    input wire logic rstn, // synchronous reset, active low
    // user side
    input wire logic start_read, // request one read, pulse
    input wire logic [ADDR_W-1:0] rd_addr, // address of the read
    output logic [DATA_W-1:0] rd_data, // word read back, registered
    output logic rd_valid, // rd_data is new, one cycle
    input wire logic start_prog, // request programming of the whole array
    output logic wr_req, // asks for the word at wr_addr, level
    output logic [ADDR_W-1:0] wr_addr, // word wanted, registered
    input wire logic [DATA_W-1:0] wr_data, // word to store
    input wire logic wr_valid, // wr_data given, taken with wr_req
    output logic busy, // a sequence is running
    output logic prog_done, // programming finished, one cycle
    // device pins
    output logic [ADDR_W-1:0] word_address_inputs, // address pins
    input wire logic [DATA_W-1:0] data_lines_i, // data pin levels
    output logic [DATA_W-1:0] data_lines_o, // program data driven
    output logic data_lines_oe, // high while we drive data pins
    output logic select_and_program_pulse, // select level, or the pulse in program mode
    output logic program_enable_supply_pin // high selects program level
);

    // cycle counts derived from times; pulse rounds down inside its window
    localparam int PULSE_CYC = PULSE_NS / uep_pkg::CLK_NS;
    localparam int LOOPS = (TOTAL_PULSE_NS + PULSE_NS - 1) / PULSE_NS;
    localparam int CNT_W = 24;
    localparam int LOOP_W = 16;

    // all state of the controller
    typedef struct packed {
        uep_pkg::uep_state_t st; // sequence state
        logic [CNT_W-1:0] cnt; // countdown of the current wait
        logic [LOOP_W-1:0] loop; // program loop number
        logic [ADDR_W-1:0] addr; // address on the pins
        logic [DATA_W-1:0] dout; // program data on the pins
        logic oe; // drive data pins
        logic sel; // select / pulse pin
        logic pe; // program enable level
        logic [DATA_W-1:0] rd_data; // captured read word
        logic rd_valid; // read done pulse
        logic prog_done; // program done pulse
    } uep_ctl_t;

    uep_ctl_t r;
    uep_ctl_t next_r;
    logic [DATA_W-1:0] data_sync; // data pins after the synchroniser

    // pin data crosses in from the device
    uep_sync3 #(
        .W(DATA_W)
    ) u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .async_in(data_lines_i),
        .stable_out(data_sync)
    );

    // sequence logic
    always_comb begin
        next_r = r;
        next_r.rd_valid = 1'b0;
        next_r.prog_done = 1'b0;
        next_r.cnt = r.cnt - 24'h000001;
        case (r.st)
            uep_pkg::ST_IDLE: begin
                next_r.cnt = r.cnt;
                if (start_prog) begin
                    // enable program mode with pulse low, pins released
                    next_r.pe = 1'b1;
                    next_r.sel = 1'b0;
                    next_r.oe = 1'b0;
                    next_r.addr = '0;
                    next_r.loop = '0;
                    next_r.cnt = CNT_W'(uep_pkg::SETUP_CYC - 1);
                    next_r.st = uep_pkg::ST_PG_ENTER;
                end else if (start_read) begin
                    // select low makes the device drive the word
                    next_r.addr = rd_addr;
                    next_r.sel = 1'b0;
                    next_r.cnt = CNT_W'(uep_pkg::ACCESS_CYC + uep_pkg::SYNC_DEPTH - 1);
                    next_r.st = uep_pkg::ST_RD_WAIT;
                end
            end
            uep_pkg::ST_RD_WAIT: begin
                // address held for the whole access time
                if (r.cnt == '0) begin
                    next_r.rd_data = data_sync;
                    next_r.rd_valid = 1'b1;
                    next_r.sel = 1'b1;
                    next_r.st = uep_pkg::ST_IDLE;
                end
            end
            uep_pkg::ST_PG_ENTER: begin
                // program enable setup before the first word
                if (r.cnt == '0) begin
                    next_r.st = uep_pkg::ST_PG_FETCH;
                end
            end
            uep_pkg::ST_PG_FETCH: begin
                // wait for the user word, then drive it
                next_r.cnt = r.cnt;
                if (wr_valid) begin
                    next_r.dout = wr_data;
                    next_r.oe = 1'b1;
                    next_r.cnt = CNT_W'(uep_pkg::SETUP_CYC - 1);
                    next_r.st = uep_pkg::ST_PG_SETUP;
                end
            end
            uep_pkg::ST_PG_SETUP: begin
                // address and data settle before the pulse
                if (r.cnt == '0) begin
                    next_r.sel = 1'b1;
                    next_r.cnt = CNT_W'(PULSE_CYC - 1);
                    next_r.st = uep_pkg::ST_PG_PULSE;
                end
            end
            uep_pkg::ST_PG_PULSE: begin
                // pulse width counted from the reference clock
                if (r.cnt == '0) begin
                    next_r.sel = 1'b0;
                    next_r.cnt = CNT_W'(uep_pkg::POST_PULSE_CYC - 1);
                    next_r.st = uep_pkg::ST_PG_HOLD;
                end
            end
            uep_pkg::ST_PG_HOLD: begin
                // data and address held after the pulse
                if (r.cnt == '0) begin
                    if (r.addr == {ADDR_W{1'b1}}) begin
                        if (r.loop == LOOP_W'(LOOPS - 1)) begin
                            // last pulse already low; free the pins first
                            next_r.oe = 1'b0;
                            next_r.cnt = CNT_W'(uep_pkg::PE_HOLD_CYC - 1);
                            next_r.st = uep_pkg::ST_PG_EXIT;
                        end else begin
                            next_r.loop = r.loop + 16'h0001;
                            next_r.addr = '0;
                            next_r.st = uep_pkg::ST_PG_FETCH;
                        end
                    end else begin
                        next_r.addr = r.addr + 1'b1;
                        next_r.st = uep_pkg::ST_PG_FETCH;
                    end
                end
            end
            uep_pkg::ST_PG_EXIT: begin
                // program enable hold, then back to read level
                if (r.cnt == '0) begin
                    next_r.pe = 1'b0;
                    next_r.cnt = CNT_W'(uep_pkg::RECOVER_CYC - 1);
                    next_r.st = uep_pkg::ST_PG_RECOVER;
                end
            end
            uep_pkg::ST_PG_RECOVER: begin
                // outputs unsettled; no read is accepted meanwhile
                if (r.cnt == '0) begin
                    next_r.sel = 1'b1;
                    next_r.prog_done = 1'b1;
                    next_r.st = uep_pkg::ST_IDLE;
                end
            end
            default: begin
                next_r.st = uep_pkg::ST_IDLE;
                next_r.sel = 1'b1;
                next_r.pe = 1'b0;
                next_r.oe = 1'b0;
            end
        endcase
    end

    // register the state; reset leaves the device deselected in read mode
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            r <= '0;
            r.st <= uep_pkg::ST_IDLE;
            r.sel <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // outputs
    assign rd_data = r.rd_data;
    assign rd_valid = r.rd_valid;
    assign prog_done = r.prog_done;
    assign wr_req = (r.st == uep_pkg::ST_PG_FETCH);
    assign wr_addr = r.addr;
    assign busy = (r.st != uep_pkg::ST_IDLE);
    assign word_address_inputs = r.addr;
    assign data_lines_o = r.dout;
    assign data_lines_oe = r.oe;
    assign select_and_program_pulse = r.sel;
    assign program_enable_supply_pin = r.pe;

endmodule // uep_programmer

//--- hw/uep_pkg.sv
// constants and state codes shared by the eprom programmer and reader
package uep_pkg;

    // reference clock period in ns
    localparam int CLK_NS = 4;

    // array shape
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;

    // read access time of the slower grade, ns
    localparam int READ_ACCESS_NS = 450;
    // input synchroniser depth seen by sampled data
    localparam int SYNC_DEPTH = 3;

    // program pulse width, ns (allowed window 100000 to 1000000)
    localparam int PULSE_NS = 1000000;
    // least total pulse time per word over all loops, ns
    localparam int TOTAL_PULSE_NS = 100000000;
    // address, data and program enable setup before the pulse, ns
    localparam int SETUP_NS = 10000;
    // wait after pulse end before address or data moves, ns
    localparam int POST_PULSE_NS = 1000;
    // program enable hold after the last pulse, ns
    localparam int PE_HOLD_NS = 500;
    // outputs invalid after program enable returns, ns
    localparam int RECOVER_NS = 10000;

    // least times round up to whole cycles
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int POST_PULSE_CYC = (POST_PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int PE_HOLD_CYC = (PE_HOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_CYC = (READ_ACCESS_NS + CLK_NS - 1) / CLK_NS;

    // controller states, one-hot
    typedef enum logic [8:0] {
        ST_IDLE = 9'h001,
        ST_RD_WAIT = 9'h002,
        ST_PG_ENTER = 9'h004,
        ST_PG_FETCH = 9'h008,
        ST_PG_SETUP = 9'h010,
        ST_PG_PULSE = 9'h020,
        ST_PG_HOLD = 9'h040,
        ST_PG_EXIT = 9'h080,
        ST_PG_RECOVER = 9'h100
    } uep_state_t;

endpackage

//--- hw/uep_sync3.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module uep_sync3 #(
    parameter int W = 8 // bus width
) (
    input wire logic ref_clk, // reference clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic [W-1:0] async_in, // pin level from outside
    output logic [W-1:0] stable_out // value once stages two and three agree
);

    // all state of the synchroniser
    typedef struct packed {
        logic [W-1:0] ff1; // first stage, read only by ff2
        logic [W-1:0] ff2; // second stage
        logic [W-1:0] ff3; // third stage
        logic [W-1:0] held; // accepted value
    } uep_sync_t;

    uep_sync_t r;
    uep_sync_t next_r;

    // shift the stages and accept a value once two and three agree
    always_comb begin
        next_r = r;
        next_r.ff1 = async_in;
        next_r.ff2 = r.ff1;
        next_r.ff3 = r.ff2;
        // bits still settling keep their old value
        next_r.held = (r.ff2 & ~(r.ff2 ^ r.ff3)) | (r.held & (r.ff2 ^ r.ff3));
    end

    // register the state
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign stable_out = r.held;

endmodule // uep_sync3

//--- dv/uep_programmer_assertions.sv
// port checker for the eprom controller, bound into the design
`timescale 1ns/10ps
module uep_programmer_assertions #(
    parameter int ADDR_W = 11, // address width
    parameter int DATA_W = 8, // word width
    parameter int PULSE_NS = 1000000 // pulse width, ns
) (
    input wire logic ref_clk, // clock
    input wire logic rstn, // reset, active low
    input wire logic start_read, // read request
    input wire logic [ADDR_W-1:0] rd_addr, // read address
    input wire logic rd_valid, // read answer
    input wire logic start_prog, // program request
    input wire logic busy, // sequence running
    input wire logic wr_req, // word wanted
    input wire logic [DATA_W-1:0] wr_data, // word given
    input wire logic wr_valid, // word present
    input wire logic prog_done, // programming over
    input wire logic [ADDR_W-1:0] word_address_inputs, // address pins
    input wire logic [DATA_W-1:0] data_lines_o, // data driven
    input wire logic data_lines_oe, // data drive enable
    input wire logic select_and_program_pulse, // select or pulse
    input wire logic program_enable_supply_pin // program level
);
    wire sel = select_and_program_pulse; // short alias
    wire pe = program_enable_supply_pin; // short alias
    logic [23:0] hi_cnt; // pulse length, wide enough for the longest legal pulse
    logic [15:0] su_cnt, lo_cnt, pel_cnt; // setup, low and recovery counters
    logic [ADDR_W-1:0] prev_a; // address one cycle ago
    // count pulse length, stable setup, time since pulse and time out of program mode
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            hi_cnt <= 24'h0;
            su_cnt <= 16'h0;
            lo_cnt <= 16'h0;
            pel_cnt <= 16'h0;
        end else begin
            hi_cnt <= (sel && pe) ? hi_cnt + 24'h1 : 24'h0;
            su_cnt <= (data_lines_oe && !sel && word_address_inputs == prev_a)
                ? su_cnt + 16'h1 : 16'h0;
            lo_cnt <= sel ? 16'h0 : lo_cnt + {15'h0, ~&lo_cnt};
            pel_cnt <= pe ? 16'h0 : pel_cnt + {15'h0, ~&pel_cnt};
        end
        prev_a <= word_address_inputs;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence rd_take;
        start_read && !busy && !start_prog;
    endsequence
    sequence rd_run;
        // counter loads 115 at the take, the answer registers one edge after it empties
        (!sel && !data_lines_oe && !pe) throughout (##115 1'b1);
    endsequence
    a_read_timing: assert property (rd_take |=> rd_run ##1 rd_valid)
        else $error("read select or answer timing wrong");
    a_read_addr: assert property (rd_take |=> word_address_inputs == $past(rd_addr))
        else $error("read address not on pins");
    a_word_taken: assert property (wr_req && wr_valid |=> data_lines_oe && !wr_req
        && data_lines_o == $past(wr_data))
        else $error("program word not driven");
    a_drive_prog_only: assert property (data_lines_oe |-> pe)
        else $error("data driven outside program mode");
    a_setup_time: assert property ($rose(sel) && pe |-> su_cnt >= uep_pkg::SETUP_CYC)
        else $error("pulse before setup time");
    a_pulse_width: assert property ($fell(sel) && pe && $past(pe)
        |-> hi_cnt == PULSE_NS / uep_pkg::CLK_NS)
        else $error("pulse width wrong");
    a_post_pulse: assert property ($changed(word_address_inputs) && pe && $past(pe)
        |-> lo_cnt >= uep_pkg::POST_PULSE_CYC)
        else $error("address moved too soon after pulse");
    a_pe_release: assert property ($fell(pe)
        |-> !sel && !data_lines_oe && lo_cnt >= uep_pkg::PE_HOLD_CYC)
        else $error("program enable released early");
    a_recover_wait: assert property (prog_done |-> !pe && pel_cnt >= uep_pkg::RECOVER_CYC - 1)
        else $error("done before output recovery");
endmodule // uep_programmer_assertions

bind uep_programmer uep_programmer_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W),
    .PULSE_NS(PULSE_NS)) uep_programmer_assertions_inst (.ref_clk(ref_clk), .rstn(rstn),
    .start_read(start_read), .rd_addr(rd_addr), .rd_valid(rd_valid), .start_prog(start_prog),
    .busy(busy), .wr_req(wr_req), .wr_data(wr_data), .wr_valid(wr_valid), .prog_done(prog_done),
    .word_address_inputs(word_address_inputs), .data_lines_o(data_lines_o),
    .data_lines_oe(data_lines_oe), .select_and_program_pulse(select_and_program_pulse),
    .program_enable_supply_pin(program_enable_supply_pin));

//--- dv/uep_eprom_model.sv
// behavioural uv eprom: array, read drive, program pulse and recovery
`timescale 1ns/10ps
module uep_eprom_model #(
    parameter int AW = 11 // address width
) (
    input wire logic [AW-1:0] addr, // address pins
    input wire logic sel, // select, or program pulse
    input wire logic pe, // high = program level
    input wire logic [7:0] host_d, // data the host drives
    input wire logic host_oe, // host drives data pins
    output logic [7:0] pin // resolved data pin level
);
    logic [7:0] mem [2**AW]; // word array
    logic recov; // outputs not yet valid
    logic pe_hi; // program level was last seen, so a fall ends program mode
    // erased array
    initial begin
        recov = 1'b0;
        pe_hi = 1'b0;
        foreach (mem[i]) mem[i] = 8'hFF;
    end
    // store on pulse end, can only clear bits
    always @(negedge sel) if (pe && host_oe) mem[addr] = mem[addr] & host_d;
    // garbage on outputs after program mode ends; the unknown-to-low step at
    // the first reset is not an exit from program mode
    always @(pe) begin
        if (pe === 1'b1) begin
            pe_hi = 1'b1;
        end else if (pe_hi) begin
            pe_hi = 1'b0;
            recov = 1'b1;
            #10000 recov = 1'b0;
        end
    end
    // pin level: host, device word, or a floating pattern
    always_comb begin
        if (host_oe) pin = host_d;
        else if (!pe && !sel && !recov) pin = mem[addr];
        else pin = ~mem[addr];
    end
endmodule // uep_eprom_model

//--- dv/test_uep_programmer.sv
// self-checking bench: reads, two programming rounds, reset after each round
`timescale 1ns/10ps
module test_uep_programmer;
    logic ref_clk, rstn, start_read, start_prog, wr_valid; // bench driven
    logic [1:0] rd_addr, wr_addr, wa; // addresses
    logic [7:0] wr_data, pin, rd_data, dlo; // data
    logic rd_valid, wr_req, busy, prog_done, oe, sel, pe; // design outputs
    integer errors, compares, seed, n, k, r; // counters and seed
    integer exp_mem [4]; // expected contents
    integer pd [4]; // words of one round
    uep_programmer #(.ADDR_W(2), .PULSE_NS(400), .TOTAL_PULSE_NS(800)) uep_programmer_inst (
        .ref_clk(ref_clk), .rstn(rstn), .start_read(start_read), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_valid(rd_valid), .start_prog(start_prog), .wr_req(wr_req),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_valid(wr_valid), .busy(busy),
        .prog_done(prog_done), .word_address_inputs(wa), .data_lines_i(pin),
        .data_lines_o(dlo), .data_lines_oe(oe), .select_and_program_pulse(sel),
        .program_enable_supply_pin(pe));
    uep_eprom_model #(.AW(2)) uep_eprom_model_inst (.addr(wa), .sel(sel), .pe(pe),
        .host_d(dlo), .host_oe(oe), .pin(pin));
    // 250 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // compare and count
    task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    // counts and verdict
    task wrap_up;
        $display("counts: %0d compares, %0d errors", compares, errors);
        if (errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // reset held five cycles
    task do_reset;
        rstn = 1'b0;
        repeat (5) @(negedge ref_clk);
        rstn = 1'b1;
    endtask
    // one read, latency and word checked
    task do_read(input integer a);
        start_read = 1'b1;
        rd_addr = a[1:0];
        @(negedge ref_clk);
        start_read = 1'b0;
        n = 0;
        while (rd_valid !== 1'b1 && n < 300) begin
            @(negedge ref_clk);
            n++;
        end
        chk(n, 116, "read latency");
        chk(busy, 0, "idle with the answer");
        chk(rd_data, exp_mem[a], "read data");
    endtask
    // program all words over every loop
    task do_prog;
        for (int i = 0; i < 4; i++) pd[i] = $random(seed) & 255;
        start_prog = 1'b1;
        @(negedge ref_clk);
        start_prog = 1'b0;
        // a read asked for while busy must be ignored
        start_read = 1'b1;
        rd_addr = 2'($random(seed));
        for (int w = 0; w < 8; w++) begin
            n = 0;
            while (wr_req !== 1'b1 && n < 4000) begin
                @(negedge ref_clk);
                n++;
            end
            start_read = 1'b0;
            chk(wr_req, 1, "word request");
            chk(wr_addr, w % 4, "word order");
            chk(pe, 1, "enable held");
            chk(busy, 1, "busy while programming");
            wr_data = pd[w % 4][7:0];
            wr_valid = 1'b1;
            @(negedge ref_clk);
            wr_valid = 1'b0;
        end
        n = 0;
        while (prog_done !== 1'b1 && n < 9000) begin
            @(negedge ref_clk);
            n++;
        end
        chk(prog_done, 1, "programming end");
        for (int i = 0; i < 4; i++) exp_mem[i] = exp_mem[i] & pd[i];
    endtask
    // watchdog
    initial begin
        #300000;
        errors++;
        $display("[ERR] %0t watchdog expired", $time);
        wrap_up;
    end
    // main sequence
    initial begin
        seed = 32'h1E7D9E17;
        errors = 0;
        compares = 0;
        {start_read, start_prog, wr_valid, rd_addr, wr_data} = 13'h0;
        foreach (exp_mem[i]) exp_mem[i] = 255;
        do_reset;
        for (k = 0; k < 4; k++) do_read(k);
        $display("test erased read done");
        for (r = 0; r < 2; r++) begin
            do_prog;
            for (k = 0; k < 4; k++) do_read(k);
            $display("test program round %0d done", r);
            do_reset;
        end
        wrap_up;
    end
endmodule // test_uep_programmer
